// ---- hw/dacupd_pkg.sv ----
package dacupd_pkg;
  // Geometry of the converter block.
  localparam int DU_NUM_CHAN = 16;
  localparam int DU_CODE_W = 12;
  localparam int DU_CHAN_W = 4;
  localparam int DU_ADDR_W = 10;
  localparam int DU_BASE_W = 6;
  localparam int DU_BASE_LSB = 4;
  localparam int DU_OFS_W = 3;
  localparam int DU_BYTE_W = 8;
  localparam int DU_NIB_W = 4;
  localparam int DU_PORT_HALF = 4;

  // Register offsets within the eight-byte window.
  localparam logic [2:0] DU_OFS_LOW = 3'h0;
  localparam logic [2:0] DU_OFS_HIGH = 3'h1;
  localparam logic [2:0] DU_OFS_CHAN = 3'h2;
  localparam logic [2:0] DU_OFS_TRIG = 3'h3;
  localparam logic [2:0] DU_OFS_PA = 3'h4;
  localparam logic [2:0] DU_OFS_PB = 3'h5;
  localparam logic [2:0] DU_OFS_PC = 3'h6;
  localparam logic [2:0] DU_OFS_CFG = 3'h7;

  // Configuration byte fields.
  localparam int DU_CFG_SET = 7;
  localparam int DU_CFG_MODE_C = 6;
  localparam int DU_CFG_MODE_A = 5;
  localparam int DU_CFG_DIR_A = 4;
  localparam int DU_CFG_DIR_CH = 3;
  localparam int DU_CFG_MODE_B = 2;
  localparam int DU_CFG_DIR_B = 1;
  localparam int DU_CFG_DIR_CL = 0;
  localparam int DU_TRIG_EN_BIT = 0;
  localparam int DU_TRIG_LINE = 0;

  // Reset and fixed values.
  localparam logic [11:0] DU_MID_CODE = 12'h800;
  localparam logic [7:0] DU_BYTE_ZERO = 8'h00;
  localparam logic [7:0] DU_BYTE_ONES = 8'hFF;
  localparam logic [7:0] DU_UPD_RD_DATA = 8'h00;
  localparam logic [3:0] DU_CHAN_RST = 4'h0;
  localparam logic [11:0] DU_CODE_ZERO = 12'h000;
endpackage

// ---- hw/dacupd_chan_if.sv ----
interface dacupd_chan_if #(
  parameter int NCH = 16,
  parameter int CW = 12
);
  logic [NCH-1:0] wr_en;
  logic [CW-1:0] code;
  logic update;

  modport ctrl (output wr_en, output code, output update);
  modport chan (input wr_en, input code, input update);
endinterface

// ---- hw/dacupd_channel.sv ----
module dacupd_channel
  import dacupd_pkg::*;
#(
  parameter int IDX = 0,
  parameter int CW = DU_CODE_W
) (
  // Clock and reset.
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  // Shared load and update signals.
  dacupd_chan_if.chan bus,
  // Present output code.
  output logic [CW-1:0] code_o
);
  logic [CW-1:0] latch_q;
  logic pending_q;

  // The input latch takes a new code and marks it pending.
  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      latch_q <= DU_CODE_ZERO;
    end else if (bus.wr_en[IDX]) begin
      latch_q <= bus.code;
    end
  end

  // A load in the same cycle as an update keeps the new code pending.
  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      pending_q <= 1'b0;
    end else if (bus.wr_en[IDX]) begin
      pending_q <= 1'b1;
    end else if (bus.update) begin
      pending_q <= 1'b0;
    end
  end

  // Only a channel with pending data changes on an update.
  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      code_o <= DU_MID_CODE;
    end else if (bus.update && pending_q) begin
      code_o <= latch_q;
    end
  end
endmodule

// ---- hw/dacupd_top.sv ----
module dacupd_top
  import dacupd_pkg::*;
#(
  parameter int NCH = DU_NUM_CHAN,
  parameter int CW = DU_CODE_W
) (
  // Clock and reset.
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  // Host I/O bus.
  input wire logic [DU_ADDR_W-1:0] io_addr_i,
  input wire logic [DU_BYTE_W-1:0] io_data_i,
  output logic [DU_BYTE_W-1:0] io_data_o,
  output logic io_data_oe_o,
  input wire logic io_rd_n_i,
  input wire logic io_wr_n_i,
  input wire logic [DU_BASE_W-1:0] base_sel_i,
  // Digital port A.
  input wire logic [DU_BYTE_W-1:0] port_a_i,
  output logic [DU_BYTE_W-1:0] port_a_o,
  output logic [DU_BYTE_W-1:0] port_a_oe_o,
  // Digital port B.
  input wire logic [DU_BYTE_W-1:0] port_b_i,
  output logic [DU_BYTE_W-1:0] port_b_o,
  output logic [DU_BYTE_W-1:0] port_b_oe_o,
  // Digital port C.
  input wire logic [DU_BYTE_W-1:0] port_c_i,
  output logic [DU_BYTE_W-1:0] port_c_o,
  output logic [DU_BYTE_W-1:0] port_c_oe_o,
  // Port operating modes.
  output logic port_a_protocol_select_o,
  output logic port_b_protocol_select_o,
  output logic port_c_protocol_select_o,
  // Converter outputs.
  output logic [NCH*CW-1:0] dac_code_o,
  output logic update_pulse_o,
  output logic hw_update_enable_o
);
  // Synchroniser stages for all bus and port pins.
  logic [DU_ADDR_W-1:0] addr_s1_q, addr_s2_q;
  logic [DU_BYTE_W-1:0] data_s1_q, data_s2_q;
  logic [DU_BASE_W-1:0] base_s1_q, base_s2_q;
  logic rd_n_s1_q, rd_n_s2_q, wr_n_s1_q, wr_n_s2_q;
  logic [DU_BYTE_W-1:0] pa_s1_q, pa_s2_q, pb_s1_q, pb_s2_q, pc_s1_q, pc_s2_q;

  // Strobe edge detection and decode.
  logic rd_act_prev_q, wr_act_prev_q;
  logic rd_act, wr_act, rd_start, wr_start, hit, rd_upd, wr_sel;
  logic [DU_OFS_W-1:0] ofs;

  // Converter staging registers.
  logic [DU_BYTE_W-1:0] code_low_bits_q;
  logic [DU_CHAN_W-1:0] channel_index_q;
  logic load_q;
  logic [DU_CHAN_W-1:0] load_chan_q;
  logic [CW-1:0] load_code_q;
  logic update_q;

  // Trigger logic.
  logic hw_update_enable_q;
  logic trig_prev_q;
  logic port_c_line_zero;
  logic trig_fall;

  // Port registers.
  logic [DU_BYTE_W-1:0] pa_q, pb_q, pc_q;
  logic [DU_BYTE_W-1:0] oe_a_q, oe_b_q, oe_c_q;
  logic mode_a_q, mode_b_q, mode_c_q;
  logic [DU_BYTE_W-1:0] rd_mux;
  logic [DU_BYTE_W-1:0] rd_data_q;
  logic rd_oe_q;

  dacupd_chan_if #(.NCH(NCH), .CW(CW)) chan_bus ();

  // Two flip-flops on every bus and port pin before any logic reads it.
  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      addr_s1_q <= '0;
      addr_s2_q <= '0;
      data_s1_q <= DU_BYTE_ZERO;
      data_s2_q <= DU_BYTE_ZERO;
      base_s1_q <= '0;
      base_s2_q <= '0;
      rd_n_s1_q <= 1'b1;
      rd_n_s2_q <= 1'b1;
      wr_n_s1_q <= 1'b1;
      wr_n_s2_q <= 1'b1;
      pa_s1_q <= DU_BYTE_ONES;
      pa_s2_q <= DU_BYTE_ONES;
      pb_s1_q <= DU_BYTE_ONES;
      pb_s2_q <= DU_BYTE_ONES;
      pc_s1_q <= DU_BYTE_ONES;
      pc_s2_q <= DU_BYTE_ONES;
    end else begin
      addr_s1_q <= io_addr_i;
      addr_s2_q <= addr_s1_q;
      data_s1_q <= io_data_i;
      data_s2_q <= data_s1_q;
      base_s1_q <= base_sel_i;
      base_s2_q <= base_s1_q;
      rd_n_s1_q <= io_rd_n_i;
      rd_n_s2_q <= rd_n_s1_q;
      wr_n_s1_q <= io_wr_n_i;
      wr_n_s2_q <= wr_n_s1_q;
      pa_s1_q <= port_a_i;
      pa_s2_q <= pa_s1_q;
      pb_s1_q <= port_b_i;
      pb_s2_q <= pb_s1_q;
      pc_s1_q <= port_c_i;
      pc_s2_q <= pc_s1_q;
    end
  end

  // Previous strobe levels, for one action per access.
  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      rd_act_prev_q <= 1'b0;
      wr_act_prev_q <= 1'b0;
    end else begin
      rd_act_prev_q <= rd_act;
      wr_act_prev_q <= wr_act;
    end
  end

  assign rd_act = ~rd_n_s2_q;
  assign wr_act = ~wr_n_s2_q;
  assign rd_start = rd_act && !rd_act_prev_q;
  assign wr_start = wr_act && !wr_act_prev_q;
  assign ofs = addr_s2_q[DU_OFS_W-1:0];
  // The upper half of the sixteen-byte window is left unanswered.
  assign hit = (addr_s2_q[DU_ADDR_W-1:DU_BASE_LSB] == base_s2_q) &&
               !addr_s2_q[DU_OFS_W];
  assign wr_sel = wr_start && hit;
  assign rd_upd = rd_start && hit && ((ofs == DU_OFS_LOW) || (ofs == DU_OFS_HIGH));

  // Converter staging and trigger enable registers.
  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      code_low_bits_q <= DU_BYTE_ZERO;
      channel_index_q <= DU_CHAN_RST;
      hw_update_enable_q <= 1'b0;
    end else if (wr_sel) begin
      if (ofs == DU_OFS_LOW) begin
        code_low_bits_q <= data_s2_q;
      end
      if (ofs == DU_OFS_CHAN) begin
        channel_index_q <= data_s2_q[DU_CHAN_W-1:0];
      end
      if (ofs == DU_OFS_TRIG) begin
        hw_update_enable_q <= data_s2_q[DU_TRIG_EN_BIT];
      end
    end
  end

  // The high-nibble write loads the assembled code into one channel.
  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      load_q <= 1'b0;
      load_chan_q <= DU_CHAN_RST;
      load_code_q <= DU_CODE_ZERO;
    end else begin
      load_q <= wr_sel && (ofs == DU_OFS_HIGH);
      load_chan_q <= channel_index_q;
      load_code_q <= {data_s2_q[DU_NIB_W-1:0], code_low_bits_q};
    end
  end

  // Port C line 0 is seen as the pin, or as the latch when driven.
  assign port_c_line_zero = oe_c_q[DU_TRIG_LINE] ? pc_q[DU_TRIG_LINE]
                                                 : pc_s2_q[DU_TRIG_LINE];
  assign trig_fall = hw_update_enable_q && trig_prev_q && !port_c_line_zero;

  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      trig_prev_q <= 1'b1;
    end else begin
      trig_prev_q <= port_c_line_zero;
    end
  end

  // A read update and a trigger update may coincide; both give one pulse.
  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      update_q <= 1'b0;
    end else begin
      update_q <= rd_upd || trig_fall;
    end
  end

  // Port data registers and configuration.
  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      pa_q <= DU_BYTE_ZERO;
      pb_q <= DU_BYTE_ZERO;
      pc_q <= DU_BYTE_ZERO;
      oe_a_q <= DU_BYTE_ZERO;
      oe_b_q <= DU_BYTE_ZERO;
      oe_c_q <= DU_BYTE_ZERO;
      mode_a_q <= 1'b0;
      mode_b_q <= 1'b0;
      mode_c_q <= 1'b0;
    end else if (wr_sel) begin
      if (ofs == DU_OFS_PA) begin
        pa_q <= data_s2_q;
      end
      if (ofs == DU_OFS_PB) begin
        pb_q <= data_s2_q;
      end
      if (ofs == DU_OFS_PC) begin
        pc_q <= data_s2_q;
      end
      if ((ofs == DU_OFS_CFG) && data_s2_q[DU_CFG_SET]) begin
        oe_a_q <= {DU_BYTE_W{!data_s2_q[DU_CFG_DIR_A]}};
        oe_b_q <= {DU_BYTE_W{!data_s2_q[DU_CFG_DIR_B]}};
        oe_c_q <= {{DU_PORT_HALF{!data_s2_q[DU_CFG_DIR_CH]}},
                   {DU_PORT_HALF{!data_s2_q[DU_CFG_DIR_CL]}}};
        mode_a_q <= data_s2_q[DU_CFG_MODE_A];
        mode_b_q <= data_s2_q[DU_CFG_MODE_B];
        mode_c_q <= data_s2_q[DU_CFG_MODE_C];
        if (!data_s2_q[DU_CFG_DIR_A]) begin
          pa_q <= DU_BYTE_ZERO;
        end
        if (!data_s2_q[DU_CFG_DIR_B]) begin
          pb_q <= DU_BYTE_ZERO;
        end
        if (!data_s2_q[DU_CFG_DIR_CL]) begin
          pc_q[DU_PORT_HALF-1:0] <= DU_BYTE_ZERO[DU_PORT_HALF-1:0];
        end
        if (!data_s2_q[DU_CFG_DIR_CH]) begin
          pc_q[DU_BYTE_W-1:DU_PORT_HALF] <= DU_BYTE_ZERO[DU_PORT_HALF-1:0];
        end
      end
    end
  end

  // Read mux: driven lines read the latch, input lines read the pin.
  always_comb begin
    rd_mux = DU_BYTE_ZERO;
    unique case (ofs)
      DU_OFS_LOW, DU_OFS_HIGH: rd_mux = DU_UPD_RD_DATA;
      DU_OFS_PA: rd_mux = (pa_q & oe_a_q) | (pa_s2_q & ~oe_a_q);
      DU_OFS_PB: rd_mux = (pb_q & oe_b_q) | (pb_s2_q & ~oe_b_q);
      DU_OFS_PC: rd_mux = (pc_q & oe_c_q) | (pc_s2_q & ~oe_c_q);
      DU_OFS_CHAN, DU_OFS_TRIG, DU_OFS_CFG: rd_mux = DU_BYTE_ZERO;
    endcase
  end

  // The data bus is driven while a decoded read strobe is active.
  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      rd_data_q <= DU_BYTE_ZERO;
      rd_oe_q <= 1'b0;
    end else begin
      rd_data_q <= rd_mux;
      rd_oe_q <= rd_act && hit;
    end
  end

  assign chan_bus.code = load_code_q;
  assign chan_bus.update = update_q;

  for (genvar g = 0; g < NCH; g++) begin : g_chan
    assign chan_bus.wr_en[g] = load_q && (load_chan_q == DU_CHAN_W'(g));

    dacupd_channel #(
      .IDX(g),
      .CW(CW)
    ) u_chan (
      .sys_clk_i(sys_clk_i),
      .resetn_i(resetn_i),
      .bus(chan_bus.chan),
      .code_o(dac_code_o[g*CW +: CW])
    );
  end

  assign io_data_o = rd_data_q;
  assign io_data_oe_o = rd_oe_q;
  assign port_a_o = pa_q;
  assign port_b_o = pb_q;
  assign port_c_o = pc_q;
  assign port_a_oe_o = oe_a_q;
  assign port_b_oe_o = oe_b_q;
  assign port_c_oe_o = oe_c_q;
  assign port_a_protocol_select_o = mode_a_q;
  assign port_b_protocol_select_o = mode_b_q;
  assign port_c_protocol_select_o = mode_c_q;
  assign update_pulse_o = update_q;
  assign hw_update_enable_o = hw_update_enable_q;
endmodule

// ---- test/dacupd_top_asserts.sv ----
module dacupd_top_asserts
  import dacupd_pkg::*;
#(
  parameter int NCH = DU_NUM_CHAN,
  parameter int CW = DU_CODE_W
) (
  // Clock and reset.
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  // Host bus.
  input wire logic [DU_ADDR_W-1:0] io_addr_i,
  input wire logic [DU_BYTE_W-1:0] io_data_i,
  input wire logic io_rd_n_i,
  input wire logic io_wr_n_i,
  input wire logic [DU_BASE_W-1:0] base_sel_i,
  input wire logic io_data_oe_o,
  // Device outputs.
  input wire logic [DU_BYTE_W-1:0] port_a_oe_o,
  input wire logic [DU_BYTE_W-1:0] port_c_oe_o,
  input wire logic port_a_protocol_select_o,
  input wire logic [NCH*CW-1:0] dac_code_o,
  input wire logic update_pulse_o,
  input wire logic hw_update_enable_o
);
  timeunit 1ns;
  timeprecision 1ps;
  wire logic [DU_ADDR_W-1:0] ba = {base_sel_i, 4'h0};
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!resetn_i);
  a_reset_state: assert property (disable iff (1'b0)
    !resetn_i |=> dac_code_o == {NCH{DU_MID_CODE}} && !hw_update_enable_o && port_a_oe_o == 8'h00)
    else $error("reset state wrong");
  a_pulse_single: assert property (update_pulse_o |=> !update_pulse_o)
    else $error("update pulse too long");
  a_code_cause: assert property ($changed(dac_code_o) && $past(resetn_i) |->
    $past(update_pulse_o))
    else $error("code changed without update");
  a_read_update: assert property (
    $fell(io_rd_n_i) && io_addr_i[9:3] == ba[9:3] && io_addr_i[2:1] == 2'b00
    |-> ##[1:6] update_pulse_o) else $error("update read gave no update");
  a_update_source: assert property ($rose(update_pulse_o) |-> hw_update_enable_o ||
    !$past(io_rd_n_i, 2) && $past(io_addr_i[2:1], 2) == 2'b00) else $error("update without cause");
  a_read_decode: assert property ($rose(io_data_oe_o) |->
    !$past(io_rd_n_i, 2) && io_addr_i[9:3] == ba[9:3]) else $error("drive without hit");
  a_trig_write: assert property ($rose(io_wr_n_i) && $past(io_addr_i) == ba + 10'h3
    |-> hw_update_enable_o == $past(io_data_i[0])) else $error("enable not taken");
  a_cfg_dir: assert property ($rose(io_wr_n_i) && $past(io_addr_i) == ba + 10'h7 &&
    $past(io_data_i[7]) |-> port_a_oe_o == {8{!$past(io_data_i[4])}} &&
    port_c_oe_o == {{4{!$past(io_data_i[3])}}, {4{!$past(io_data_i[0])}}})
    else $error("direction wrong");
  a_cfg_mode: assert property ($rose(io_wr_n_i) && $past(io_addr_i) == ba + 10'h7 &&
    $past(io_data_i[7]) |-> port_a_protocol_select_o == $past(io_data_i[5]))
    else $error("mode wrong");
  a_cfg_refuse: assert property ($rose(io_wr_n_i) && $past(io_addr_i) == ba + 10'h7 &&
    !$past(io_data_i[7]) |-> port_a_oe_o == $past(port_a_oe_o, 6)) else $error("bad config taken");
endmodule

bind dacupd_top dacupd_top_asserts #(.NCH(NCH), .CW(CW)) dacupd_top_asserts_i (
  .sys_clk_i(sys_clk_i),
  .resetn_i(resetn_i),
  .io_addr_i(io_addr_i),
  .io_data_i(io_data_i),
  .io_rd_n_i(io_rd_n_i),
  .io_wr_n_i(io_wr_n_i),
  .base_sel_i(base_sel_i),
  .io_data_oe_o(io_data_oe_o),
  .port_a_oe_o(port_a_oe_o),
  .port_c_oe_o(port_c_oe_o),
  .port_a_protocol_select_o(port_a_protocol_select_o),
  .dac_code_o(dac_code_o),
  .update_pulse_o(update_pulse_o),
  .hw_update_enable_o(hw_update_enable_o)
);

// ---- test/dacupd_host_model.sv ----
module dacupd_host_model
  import dacupd_pkg::*;
(
  // Clock and read data.
  input wire logic sys_clk_i,
  input wire logic [DU_BYTE_W-1:0] rd_data_i,
  input wire logic rd_oe_i,
  // Host bus lines.
  output logic [DU_ADDR_W-1:0] io_addr_o,
  output logic [DU_BYTE_W-1:0] io_data_o,
  output logic io_rd_n_o,
  output logic io_wr_n_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    io_addr_o = 10'h000;
    io_data_o = 8'h00;
    io_rd_n_o = 1'b1;
    io_wr_n_o = 1'b1;
  end
  // Address and data settle three clocks before the strobe falls.
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    io_addr_o <= a;
    io_data_o <= d;
    repeat (3) @(posedge sys_clk_i);
    io_wr_n_o <= 1'b0;
    repeat (5) @(posedge sys_clk_i);
    io_wr_n_o <= 1'b1;
    io_data_o <= ~d;
    repeat (3) @(posedge sys_clk_i);
  endtask
  // Update reads return data of no meaning; callers ignore it.
  task automatic rd(input logic [9:0] a, output logic [7:0] q, output logic v);
    @(posedge sys_clk_i);
    io_addr_o <= a;
    repeat (3) @(posedge sys_clk_i);
    io_rd_n_o <= 1'b0;
    repeat (6) @(posedge sys_clk_i);
    q = rd_data_i;
    v = rd_oe_i;
    io_rd_n_o <= 1'b1;
    repeat (3) @(posedge sys_clk_i);
  endtask
endmodule

// ---- test/dacupd_top_tb.sv ----
module dacupd_top_tb
  import dacupd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [9:0] A0 = 10'h300;
  logic sys_clk_i, resetn_i, io_rd_n_i, io_wr_n_i, upd_p, trig_en, d_oe;
  logic [5:0] base;
  int n_upd = 0;
  int n_exp = 0;
  logic [9:0] io_addr_i;
  logic [7:0] io_data_i, io_data_o, q, cx, pa, pb, pc, pa_o, pb_o, pc_o, pb_oe;
  logic [7:0] port_a_oe_o, port_c_oe_o;
  logic [2:0] mode;
  logic [DU_NUM_CHAN*DU_CODE_W-1:0] dac_code_o;
  logic [11:0] ex [16];
  logic [11:0] pd [16];
  logic [15:0] pv;
  int err_total = 0;
  int total_checks = 0;
  int cyc = 0;
  assign pa = (port_a_oe_o & pa_o) | (~port_a_oe_o & 8'h3C);
  assign pb = (pb_oe & pb_o) | (~pb_oe & 8'hC5);
  assign pc = (port_c_oe_o & pc_o) | (~port_c_oe_o & cx);
  dacupd_top dacupd_top_i (
    .sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .io_addr_i(io_addr_i),
    .io_data_i(io_data_i), .io_data_o(io_data_o), .io_data_oe_o(d_oe),
    .io_rd_n_i(io_rd_n_i), .io_wr_n_i(io_wr_n_i), .base_sel_i(base),
    .port_a_i(pa), .port_a_o(pa_o), .port_a_oe_o(port_a_oe_o),
    .port_b_i(pb), .port_b_o(pb_o), .port_b_oe_o(pb_oe),
    .port_c_i(pc), .port_c_o(pc_o), .port_c_oe_o(port_c_oe_o),
    .port_a_protocol_select_o(mode[2]), .port_b_protocol_select_o(mode[1]),
    .port_c_protocol_select_o(mode[0]), .dac_code_o(dac_code_o),
    .update_pulse_o(upd_p), .hw_update_enable_o(trig_en));
  dacupd_host_model dacupd_host_model_i (
    .sys_clk_i(sys_clk_i), .rd_data_i(io_data_o), .rd_oe_i(d_oe), .io_addr_o(io_addr_i),
    .io_data_o(io_data_i), .io_rd_n_o(io_rd_n_i), .io_wr_n_o(io_wr_n_i));
  initial begin
    sys_clk_i = 1'b0;
    forever #25 sys_clk_i = ~sys_clk_i;
  end
  task automatic wrb(input logic [9:0] a, input logic [7:0] d);
    dacupd_host_model_i.wr(a, d);
  endtask
  task automatic rdb(input logic [9:0] a);
    logic v;
    dacupd_host_model_i.rd(a, q, v);
    chk_b("data_oe", {7'h00, (a[9:4] == base) && !a[3]}, {7'h00, v});
  endtask
  task automatic chk_b(input string n, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      err_total++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk_all();
    for (int i = 0; i < 16; i++) begin
      total_checks++;
      if (dac_code_o[i*DU_CODE_W +: DU_CODE_W] !== ex[i]) begin
        err_total++;
        $display("BAD code %0d expected %h seen %h", i, ex[i], dac_code_o[i*DU_CODE_W +: 12]);
      end
    end
  endtask
  // Loads one channel through the low, channel and high registers.
  task automatic ld(input int c, input logic [11:0] v);
    wrb(A0, v[7:0]);
    wrb(A0 + 10'h2, {4'hF, c[3:0]});
    wrb(A0 + 10'h1, {4'hA, v[11:8]});
    pd[c] = v;
    pv[c] = 1'b1;
  endtask
  task automatic upd();
    for (int i = 0; i < 16; i++) if (pv[i]) ex[i] = pd[i];
    pv = 16'h0000;
    n_exp++;
  endtask
  task automatic rst(input int n);
    @(posedge sys_clk_i);
    resetn_i <= 1'b0;
    repeat (n) @(posedge sys_clk_i);
    resetn_i <= 1'b1;
    repeat (2) @(posedge sys_clk_i);
    for (int i = 0; i < 16; i++) ex[i] = DU_MID_CODE;
    pv = 16'h0000;
    chk_all();
    chk_b("trig_en", 8'h00, {7'h0, trig_en});
    chk_b("oe_ac", 8'h00, port_a_oe_o | port_c_oe_o);
  endtask
  task automatic tend(input string n);
    $display("test %s done", n);
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge sys_clk_i) begin
    cyc++;
    if (upd_p === 1'b1) n_upd++;
    if (cyc == 5000) begin
      err_total++;
      complete_run();
    end
  end
  initial begin
    resetn_i = 1'b0;
    cx = 8'hFF;
    base = A0[9:4];
    rst(10);
    tend("reset");
    ld(5, 12'h9AB);
    ld(7, 12'h456);
    chk_all();
    rdb(A0 + 10'h2);
    chk_all();
    rdb(A0);
    upd();
    chk_all();
    ld(0, 12'h123);
    rdb(A0 + 10'h1);
    upd();
    chk_all();
    tend("update");
    wrb(A0 + 10'h3, 8'hFE);
    chk_b("trig_en", 8'h00, {7'h0, trig_en});
    wrb(A0 + 10'h3, 8'h01);
    chk_b("trig_en", 8'h01, {7'h0, trig_en});
    ld(15, 12'hFFF);
    cx[0] <= 1'b0;
    repeat (8) @(posedge sys_clk_i);
    upd();
    chk_all();
    ld(1, 12'h00F);
    repeat (8) @(posedge sys_clk_i);
    chk_all();
    rdb(A0);
    upd();
    chk_all();
    cx[0] <= 1'b1;
    ld(2, 12'h001);
    wrb(A0 + 10'h7, 8'h80);
    repeat (4) @(posedge sys_clk_i);
    upd();
    chk_all();
    chk_b("updates", n_exp[7:0], n_upd[7:0]);
    tend("trigger");
    rst(2);
    tend("second reset");
    wrb(A0 + 10'h7, 8'h80);
    chk_b("oe_a", 8'hFF, port_a_oe_o);
    wrb(A0 + 10'h4, 8'h5A);
    rdb(A0 + 10'h4);
    chk_b("port_a", 8'h5A, q);
    wrb(A0 + 10'h7, 8'h1B);
    chk_b("oe_a", 8'hFF, port_a_oe_o);
    wrb(A0 + 10'h7, 8'h9B);
    chk_b("oe_c", 8'h00, port_c_oe_o);
    rdb(A0 + 10'h5);
    chk_b("port_b", 8'hC5, q);
    wrb(A0 + 10'h7, 8'hEC);
    chk_b("oe_c", 8'h0F, port_c_oe_o);
    chk_b("mode", 8'h07, {5'h00, mode});
    rdb(A0 + 10'h4);
    chk_b("port_a", 8'h00, q);
    rdb(A0 + 10'h6);
    chk_b("port_c", 8'hF0, q);
    tend("ports");
    wrb(A0 + 10'hC, 8'h77);
    wrb(10'h314, 8'h66);
    rdb(A0 + 10'hC);
    rdb(A0 + 10'h4);
    chk_b("port_a", 8'h00, q);
    base <= 6'h22;
    wrb(10'h224, 8'h3C);
    rdb(10'h224);
    chk_b("port_a", 8'h3C, q);
    rdb(A0 + 10'h4);
    tend("decode");
    complete_run();
  end
endmodule
